/* rtl/aosc_pkg.sv */
package aosc_pkg;
    localparam int DW = 32;
    localparam int AW = 8;
    localparam int ALM_N = 4;
    localparam int DO_N = 4;
    localparam int CH_W = 3;
    localparam int RD_W = 16;
    // Register offsets
    localparam logic [AW-1:0] A_CTRL = 8'h00;
    localparam logic [AW-1:0] A_DOWR = 8'h04;
    localparam logic [AW-1:0] A_SAFE = 8'h08;
    localparam logic [AW-1:0] A_PWRON = 8'h0C;
    localparam logic [AW-1:0] A_COMM = 8'h10;
    localparam logic [AW-1:0] A_COMMACT = 8'h14;
    localparam logic [AW-1:0] A_FMT = 8'h18;
    localparam logic [AW-1:0] A_ALMCLR = 8'h1C;
    localparam logic [AW-1:0] A_ALMSTAT = 8'h20;
    localparam logic [AW-1:0] A_CSEL = 8'h24;
    localparam logic [AW-1:0] A_CDATA = 8'h28;
    localparam logic [AW-1:0] A_CINFO = 8'h2C;
    localparam logic [AW-1:0] A_PSEL = 8'h30;
    localparam logic [2:0] A_ALM_HI = 3'h2;
    // Out-of-range codes
    localparam logic [DW-1:0] OVR_ENG = 32'h0001869F;
    localparam logic [DW-1:0] UND_ENG = 32'hFFFE7961;
    localparam logic [DW-1:0] OVR_PCT = 32'h0001869F;
    localparam logic [DW-1:0] UND_PCT = 32'hFFFE7961;
    localparam logic [DW-1:0] OVR_HEX = 32'h00007FFF;
    localparam logic [DW-1:0] UND_HEX = 32'h00008000;
    localparam logic [1:0] FMT_ENG = 2'h0;
    localparam logic [1:0] FMT_PCT = 2'h1;
    localparam logic [1:0] FMT_HEX = 2'h2;
    // Communication settings
    localparam logic [7:0] COMM_ADDR_DEF = 8'h01;
    localparam logic [7:0] INIT_ADDR = 8'h00;
    localparam logic [2:0] BAUD_9600 = 3'h3;
    localparam logic [2:0] BAUD_DEF = 3'h3;
    localparam logic PROTO_MODBUS = 1'b1;
    localparam logic PROTO_ASCII = 1'b0;
    localparam logic [7:0] MB_FUNC_PROTO = 8'h46;
    localparam logic [7:0] MB_SUB_PROTO = 8'h06;
    localparam logic [7:0] MB_BYTE8_ASCII = 8'h01;
    localparam logic [7:0] PSEL_N_MODBUS = 8'h01;
    localparam int MB_DATA_BITS = 8;
    localparam int MB_STOP_BITS = 1;
    localparam int CLK_HZ = 25_000_000;
    // Frame characters
    localparam logic [7:0] CHR_CR = 8'h0D;
    localparam logic [7:0] CKS_MASK = 8'hFF;
    // Coefficient word layout
    localparam int FLT_SIGN = 31;
    localparam int FLT_EMSB = 30;
    localparam int FLT_ELSB = 23;
    localparam logic [7:0] FLT_BIAS = 8'h7F;
    localparam int COEF_AW = 5;
    localparam int KELVIN_CK = 27315;
    // Alarm configuration and communication register fields
    localparam int AC_EN = 0;
    localparam int AC_LATCH = 1;
    localparam int AC_HIGH = 2;
    localparam int AC_CH_LSB = 4;
    localparam int AC_PORT_LSB = 8;
    localparam int CM_BAUD_LSB = 8;
    localparam int CM_CKS = 12;
    localparam int CM_PROTO = 13;

    typedef enum logic [1:0] {ST_BOOT, ST_SETTLE, ST_LOAD, ST_RUN} aosc_state_t;

    // Clock divider for a Modbus line rate code
    function automatic logic [15:0] aosc_baud_div(input logic [2:0] code);
        int rate;
        case (code)
            3'h0: rate = 1200;
            3'h1: rate = 2400;
            3'h2: rate = 4800;
            3'h3: rate = 9600;
            3'h4: rate = 19200;
            3'h5: rate = 38400;
            3'h6: rate = 57600;
            default: rate = 115200;
        endcase
        return 16'(CLK_HZ / rate);
    endfunction
endpackage

/* rtl/aosc_coef_mem.sv */
`timescale 1ns/1ps
module aosc_coef_mem
    import aosc_pkg::*;
#(
    parameter int AWD = COEF_AW,
    parameter int W   = DW
) (
    input  wire logic           clk_i,
    input  wire logic           we_i,
    input  wire logic [AWD-1:0] addr_i,
    input  wire logic [W-1:0]   wdata_i,
    output logic      [W-1:0]   rdata_o
);
    logic [W-1:0] mem [2**AWD];

    // Write-first storage with registered read
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= we_i ? wdata_i : mem[addr_i];
    end
endmodule

/* rtl/aosc_alarm.sv */
`timescale 1ns/1ps
module aosc_alarm
    import aosc_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            rst_n_i,
    input  wire logic            en_i,
    input  wire logic            latch_i,
    input  wire logic            high_i,
    input  wire logic [CH_W-1:0] chan_i,
    input  wire logic [RD_W-1:0] limit_i,
    input  wire logic            conv_vld_i,
    input  wire logic [CH_W-1:0] conv_ch_i,
    input  wire logic [RD_W-1:0] conv_i,
    input  wire logic            over_i,
    input  wire logic            under_i,
    input  wire logic            clr_i,
    output logic                 stat_d_o,
    output logic                 stat_q_o
);
    logic beyond;
    logic hit;

    // Limit check on a fresh result for this channel
    always_comb begin
        if (high_i) begin
            beyond = over_i || ($signed(conv_i) > $signed(limit_i));
        end else begin
            beyond = under_i || ($signed(conv_i) < $signed(limit_i));
        end
        hit = en_i && conv_vld_i && (conv_ch_i == chan_i);
        stat_d_o = stat_q_o;
        if (!en_i) begin
            stat_d_o = 1'b0;
        end else if (hit && !latch_i) begin
            stat_d_o = beyond;
        end else if (hit && beyond) begin
            stat_d_o = 1'b1;
        end else if (clr_i && latch_i) begin
            stat_d_o = 1'b0;
        end
    end

    // Alarm status flag
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stat_q_o <= 1'b0;
        end else begin
            stat_q_o <= stat_d_o;
        end
    end
endmodule

/* rtl/aosc_top.sv */
// Behaviour
// - Out-of-range: +/-9999.9 eng, +/-999.99 percent
// - Hex and Modbus readings: 7FFF over, 8000 under
// - Coefficients are 32-bit single-precision floats
// - Coefficients feed the Steinhart-Hart relation, Kelvin offset; the code only stores and reads them back, KELVIN_CK is unused
// - Watchdog timeout loads safe value to outputs
// - Output writes ignored while timeout status set
// - Power-on loads safe or power-on value
// - Channel readings compared with high/low limits
// - Alarm-assigned ports follow only alarm status
// - Momentary alarm tracks the reading
// - Latched alarm holds until host clears
// - Modbus framing 8N1 at 1200-115200 bps
// - Modbus is the factory-default protocol
// - Function 46h/06h byte8=1 selects ASCII
// - Set-protocol N=1 in INIT selects Modbus
// - INIT start: address 00, 9600, no checksum, ASCII
// - New comm settings apply after power-on
// - Checksum is low byte of character sum
// - Frames end with carriage return
`timescale 1ns/1ps
module aosc_top
    import aosc_pkg::*;
#(
    parameter logic [DO_N-1:0] SAFE_DEF  = '0,
    parameter logic [DO_N-1:0] PWRON_DEF = '0
) (
    input  wire logic            CLK_SYS_I,
    input  wire logic            RST_N_I,
    input  wire logic [AW-1:0]   REG_ADDR_I,
    input  wire logic [DW-1:0]   REG_WDATA_I,
    input  wire logic            REG_WR_I,
    input  wire logic            REG_RD_I,
    output logic      [DW-1:0]   REG_RDATA_O,
    input  wire logic            INIT_SW_I,
    input  wire logic            WDT_TIMEOUT_I,
    input  wire logic            WDT_STATUS_NV_I,
    input  wire logic            CONV_VALID_I,
    input  wire logic [CH_W-1:0] CONV_CHAN_I,
    input  wire logic [RD_W-1:0] CONV_DATA_I,
    input  wire logic            CONV_OVER_I,
    input  wire logic            CONV_UNDER_I,
    output logic                 RD_VALID_O,
    output logic      [DW-1:0]   RD_DATA_O,
    output logic      [DO_N-1:0] DO_O,
    input  wire logic [7:0]      FRM_CHAR_I,
    input  wire logic            FRM_CHAR_VALID_I,
    output logic      [7:0]      FRM_CKSUM_O,
    output logic                 FRM_END_O,
    output logic                 PROTO_MODBUS_O,
    output logic      [7:0]      COMM_ADDR_O,
    output logic      [15:0]     BAUD_DIV_O,
    output logic                 CKSUM_EN_O,
    output logic                 INIT_MODE_O
);
    aosc_state_t      st_q;
    logic [1:0]       init_sync_q;
    logic             wdt_q;
    logic [DO_N-1:0]  do_val_q;
    logic [DO_N-1:0]  safe_q;
    logic [DO_N-1:0]  pwron_q;
    logic [7:0]       cm_addr_q  = COMM_ADDR_DEF;
    logic [2:0]       cm_baud_q  = BAUD_DEF;
    logic             cm_cks_q   = 1'b0;
    logic             cm_proto_q = PROTO_MODBUS;
    logic [1:0]       fmt_q;
    logic [COEF_AW-1:0] csel_q;
    logic [RD_W-1:0]  lim_q [ALM_N];
    logic [11:0]      cfg_q [ALM_N];
    logic [ALM_N-1:0] stat_d;
    logic [ALM_N-1:0] stat_q;
    logic [DW-1:0]    coef_rd;
    logic [7:0]       cks_q;
    logic [DW-1:0]    rdata_d;
    logic             wr_ctrl;
    logic             wr_do;
    logic             wr_comm;
    logic             wr_psel;
    logic             wr_clr;
    logic             wr_csel;
    logic             wr_cdata;
    logic             alm_sel;
    logic [1:0]       alm_idx;

    // Reading code with out-of-range substitution
    function automatic logic [DW-1:0] rd_code(input logic ovr, input logic und,
                                              input logic [1:0] fmt, input logic mb,
                                              input logic [RD_W-1:0] d);
        logic hex;
        hex = mb || (fmt == FMT_HEX);
        if (ovr) begin
            rd_code = hex ? OVR_HEX : (fmt == FMT_PCT) ? OVR_PCT : OVR_ENG;
        end else if (und) begin
            rd_code = hex ? UND_HEX : (fmt == FMT_PCT) ? UND_PCT : UND_ENG;
        end else if (hex) begin
            rd_code = {{(DW-RD_W){1'b0}}, d};
        end else begin
            rd_code = {{(DW-RD_W){d[RD_W-1]}}, d};
        end
    endfunction

    // Sign and unbiased exponent of a float word
    function automatic logic [DW-1:0] flt_info(input logic [DW-1:0] f);
        logic [7:0] e;
        e = f[FLT_EMSB:FLT_ELSB] - FLT_BIAS;
        flt_info = {f[FLT_SIGN], {(DW-9){1'b0}}, e};
    endfunction

    // Register write decode
    always_comb begin
        alm_sel  = (REG_ADDR_I[AW-1:5] == A_ALM_HI);
        alm_idx  = REG_ADDR_I[4:3];
        wr_ctrl  = REG_WR_I && (REG_ADDR_I == A_CTRL);
        wr_do    = REG_WR_I && (REG_ADDR_I == A_DOWR);
        wr_comm  = REG_WR_I && (REG_ADDR_I == A_COMM);
        wr_psel  = REG_WR_I && (REG_ADDR_I == A_PSEL);
        wr_clr   = REG_WR_I && (REG_ADDR_I == A_ALMCLR);
        wr_csel  = REG_WR_I && (REG_ADDR_I == A_CSEL);
        wr_cdata = REG_WR_I && (REG_ADDR_I == A_CDATA);
    end

    // Recovery switch synchroniser
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            init_sync_q <= '0;
        end else begin
            init_sync_q <= {init_sync_q[0], INIT_SW_I};
        end
    end

    // Start-up sequencer: settle switch, load, run
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            st_q <= ST_BOOT;
        end else begin
            case (st_q)
                ST_BOOT:   st_q <= ST_SETTLE;
                ST_SETTLE: st_q <= ST_LOAD;
                ST_LOAD:   st_q <= ST_RUN;
                default:   st_q <= ST_RUN;
            endcase
        end
    end

    // Active communication settings, taken only at start-up
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            INIT_MODE_O    <= 1'b0;
            PROTO_MODBUS_O <= PROTO_MODBUS;
            COMM_ADDR_O    <= COMM_ADDR_DEF;
            BAUD_DIV_O     <= aosc_baud_div(BAUD_DEF);
            CKSUM_EN_O     <= 1'b0;
        end else if (st_q == ST_LOAD) begin
            INIT_MODE_O <= init_sync_q[1];
            if (init_sync_q[1]) begin
                PROTO_MODBUS_O <= PROTO_ASCII;
                COMM_ADDR_O    <= INIT_ADDR;
                BAUD_DIV_O     <= aosc_baud_div(BAUD_9600);
                CKSUM_EN_O     <= 1'b0;
            end else begin
                PROTO_MODBUS_O <= cm_proto_q;
                COMM_ADDR_O    <= cm_addr_q;
                BAUD_DIV_O     <= aosc_baud_div(cm_baud_q);
                CKSUM_EN_O     <= cm_cks_q;
            end
        end
    end

    // Stored communication settings and protocol selection
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            // Nonvolatile: power-on reset keeps what the host stored
        end else if (wr_comm) begin
            cm_addr_q <= REG_WDATA_I[7:0];
            cm_baud_q <= REG_WDATA_I[CM_BAUD_LSB +: 3];
            cm_cks_q  <= REG_WDATA_I[CM_CKS];
        end else if (wr_psel && REG_WDATA_I[24]) begin
            if (REG_WDATA_I[23:16] == PSEL_N_MODBUS && INIT_MODE_O) begin
                cm_proto_q <= PROTO_MODBUS;
            end
        end else if (wr_psel) begin
            if (REG_WDATA_I[7:0] == MB_FUNC_PROTO && REG_WDATA_I[15:8] == MB_SUB_PROTO
                && REG_WDATA_I[23:16] == MB_BYTE8_ASCII) begin
                cm_proto_q <= PROTO_ASCII;
            end
        end
    end

    // Host watchdog timeout status, set wins over clear
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            wdt_q <= 1'b0;
        end else if (st_q == ST_LOAD) begin
            wdt_q <= WDT_STATUS_NV_I || WDT_TIMEOUT_I;
        end else if (WDT_TIMEOUT_I) begin
            wdt_q <= 1'b1;
        end else if (wr_ctrl && REG_WDATA_I[0]) begin
            wdt_q <= 1'b0;
        end
    end

    // Safe and power-on values
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            safe_q  <= SAFE_DEF;
            pwron_q <= PWRON_DEF;
        end else begin
            if (REG_WR_I && REG_ADDR_I == A_SAFE) begin
                safe_q <= REG_WDATA_I[DO_N-1:0];
            end
            if (REG_WR_I && REG_ADDR_I == A_PWRON) begin
                pwron_q <= REG_WDATA_I[DO_N-1:0];
            end
        end
    end

    // Host-owned output value
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            do_val_q <= '0;
        end else if (st_q == ST_LOAD) begin
            do_val_q <= WDT_STATUS_NV_I ? safe_q : pwron_q;
        end else if (WDT_TIMEOUT_I) begin
            do_val_q <= safe_q;
        end else if (wr_do && !wdt_q) begin
            do_val_q <= REG_WDATA_I[DO_N-1:0];
        end
    end

    // Data format and coefficient select
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            fmt_q  <= FMT_ENG;
            csel_q <= '0;
        end else begin
            if (REG_WR_I && REG_ADDR_I == A_FMT) begin
                fmt_q <= REG_WDATA_I[1:0];
            end
            if (wr_csel) begin
                csel_q <= REG_WDATA_I[COEF_AW-1:0];
            end
        end
    end

    // Alarm limits and configuration
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            for (int i = 0; i < ALM_N; i++) begin
                lim_q[i] <= '0;
                cfg_q[i] <= '0;
            end
        end else if (REG_WR_I && alm_sel && !REG_ADDR_I[2]) begin
            lim_q[alm_idx] <= REG_WDATA_I[RD_W-1:0];
        end else if (REG_WR_I && alm_sel) begin
            cfg_q[alm_idx] <= REG_WDATA_I[11:0];
        end
    end

    // One limit checker per alarm
    for (genvar g = 0; g < ALM_N; g++) begin : g_alm
        aosc_alarm u_alm (
            .clk_i      (CLK_SYS_I),
            .rst_n_i    (RST_N_I),
            .en_i       (cfg_q[g][AC_EN]),
            .latch_i    (cfg_q[g][AC_LATCH]),
            .high_i     (cfg_q[g][AC_HIGH]),
            .chan_i     (cfg_q[g][AC_CH_LSB +: CH_W]),
            .limit_i    (lim_q[g]),
            .conv_vld_i (CONV_VALID_I),
            .conv_ch_i  (CONV_CHAN_I),
            .conv_i     (CONV_DATA_I),
            .over_i     (CONV_OVER_I),
            .under_i    (CONV_UNDER_I),
            .clr_i      (wr_clr && REG_WDATA_I[g]),
            .stat_d_o   (stat_d[g]),
            .stat_q_o   (stat_q[g])
        );
    end

    // Output ports: alarm-owned ports follow alarm status only
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            DO_O <= '0;
        end else begin
            for (int p = 0; p < DO_N; p++) begin
                logic own;
                logic lvl;
                own = 1'b0;
                lvl = 1'b0;
                for (int a = 0; a < ALM_N; a++) begin
                    if (cfg_q[a][AC_EN] && cfg_q[a][AC_PORT_LSB +: 3] == 3'(p)) begin
                        own = 1'b1;
                        lvl = lvl | stat_d[a];
                    end
                end
                DO_O[p] <= own ? lvl : do_val_q[p];
            end
        end
    end

    // Reading delivery with out-of-range codes
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            RD_VALID_O <= 1'b0;
            RD_DATA_O  <= '0;
        end else begin
            RD_VALID_O <= CONV_VALID_I;
            if (CONV_VALID_I) begin
                RD_DATA_O <= rd_code(CONV_OVER_I, CONV_UNDER_I, fmt_q,
                                     PROTO_MODBUS_O, CONV_DATA_I);
            end
        end
    end

    // Frame checksum accumulator, closed by carriage return
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            cks_q       <= '0;
            FRM_CKSUM_O <= '0;
            FRM_END_O   <= 1'b0;
        end else begin
            FRM_END_O <= 1'b0;
            if (FRM_CHAR_VALID_I && FRM_CHAR_I == CHR_CR) begin
                FRM_CKSUM_O <= cks_q & CKS_MASK;
                FRM_END_O   <= 1'b1;
                cks_q       <= '0;
            end else if (FRM_CHAR_VALID_I) begin
                cks_q <= 8'(cks_q + FRM_CHAR_I);
            end
        end
    end

    // Coefficient store for user-defined Steinhart-Hart types
    aosc_coef_mem u_coef (
        .clk_i   (CLK_SYS_I),
        .we_i    (wr_cdata),
        .addr_i  (wr_csel ? REG_WDATA_I[COEF_AW-1:0] : csel_q),
        .wdata_i (REG_WDATA_I),
        .rdata_o (coef_rd)
    );

    // Register read mux
    always_comb begin
        rdata_d = '0;
        if (REG_ADDR_I == A_CTRL) begin
            rdata_d = {29'h0, PROTO_MODBUS_O, INIT_MODE_O, wdt_q};
        end else if (REG_ADDR_I == A_DOWR) begin
            rdata_d = {{(DW-DO_N){1'b0}}, DO_O};
        end else if (REG_ADDR_I == A_SAFE) begin
            rdata_d = {{(DW-DO_N){1'b0}}, safe_q};
        end else if (REG_ADDR_I == A_PWRON) begin
            rdata_d = {{(DW-DO_N){1'b0}}, pwron_q};
        end else if (REG_ADDR_I == A_COMM) begin
            rdata_d = {18'h0, cm_proto_q, cm_cks_q, 1'b0, cm_baud_q, cm_addr_q};
        end else if (REG_ADDR_I == A_COMMACT) begin
            rdata_d = {BAUD_DIV_O, 2'h0, PROTO_MODBUS_O, CKSUM_EN_O, 4'h0, COMM_ADDR_O};
        end else if (REG_ADDR_I == A_FMT) begin
            rdata_d = {30'h0, fmt_q};
        end else if (REG_ADDR_I == A_ALMSTAT) begin
            rdata_d = {{(DW-ALM_N){1'b0}}, stat_q};
        end else if (REG_ADDR_I == A_CSEL) begin
            rdata_d = {{(DW-COEF_AW){1'b0}}, csel_q};
        end else if (REG_ADDR_I == A_CDATA) begin
            rdata_d = coef_rd;
        end else if (REG_ADDR_I == A_CINFO) begin
            rdata_d = flt_info(coef_rd);
        end else if (alm_sel && !REG_ADDR_I[2]) begin
            rdata_d = {{(DW-RD_W){1'b0}}, lim_q[alm_idx]};
        end else if (alm_sel) begin
            rdata_d = {20'h0, cfg_q[alm_idx]};
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            REG_RDATA_O <= '0;
        end else begin
            REG_RDATA_O <= REG_RD_I ? rdata_d : '0;
        end
    end
endmodule

/* verification/aosc_chk_sva.sv */
`timescale 1ns/1ps
module aosc_chk
    import aosc_pkg::*;
(
    input  wire logic            CLK_SYS_I,
    input  wire logic            RST_N_I,
    input  wire logic            CONV_VALID_I,
    input  wire logic            CONV_OVER_I,
    input  wire logic            CONV_UNDER_I,
    input  wire logic            RD_VALID_O,
    input  wire logic [DW-1:0]   RD_DATA_O,
    input  wire logic [7:0]      FRM_CHAR_I,
    input  wire logic            FRM_CHAR_VALID_I,
    input  wire logic            FRM_END_O,
    input  wire logic            PROTO_MODBUS_O,
    input  wire logic [7:0]      COMM_ADDR_O,
    input  wire logic [15:0]     BAUD_DIV_O,
    input  wire logic            CKSUM_EN_O,
    input  wire logic            INIT_MODE_O
);
    logic [2:0] run_q;
    // Saturating count of edges since reset release
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I)
            run_q <= 3'h0;
        else if (run_q != 3'h7)
            run_q <= run_q + 3'h1;
    end
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);
    // Reading path, wire codes and settings
    rd_pulse_a: assert property (CONV_VALID_I |=> RD_VALID_O)
        else $error("reading pulse missing");
    rd_quiet_a: assert property (!CONV_VALID_I |=> !RD_VALID_O)
        else $error("reading pulse without result");
    ovr_hex_a: assert property (CONV_VALID_I && CONV_OVER_I && PROTO_MODBUS_O
        |=> RD_DATA_O == OVR_HEX) else $error("wrong over-range code");
    und_hex_a: assert property (CONV_VALID_I && CONV_UNDER_I && PROTO_MODBUS_O
        |=> RD_DATA_O == UND_HEX) else $error("wrong under-range code");
    cr_end_a: assert property (FRM_CHAR_VALID_I && FRM_CHAR_I == CHR_CR |=> FRM_END_O)
        else $error("frame end missing");
    end_cause_a: assert property (FRM_END_O |-> $past(FRM_CHAR_VALID_I && FRM_CHAR_I == CHR_CR))
        else $error("frame end without terminator");
    init_set_a: assert property (run_q == 3'h7 && INIT_MODE_O |-> !PROTO_MODBUS_O && !CKSUM_EN_O
        && COMM_ADDR_O == INIT_ADDR && BAUD_DIV_O == 16'h0A2C) else $error("bad recovery settings");
    comm_hold_a: assert property (run_q == 3'h7 |-> $stable(PROTO_MODBUS_O) && $stable(CKSUM_EN_O)
        && $stable(COMM_ADDR_O) && $stable(BAUD_DIV_O)) else $error("settings changed in run");
    cover property (CONV_VALID_I && CONV_OVER_I);
    cover property (FRM_END_O);
    cover property (run_q == 3'h7 && INIT_MODE_O);
endmodule

bind aosc_top aosc_chk u_chk (
    .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .CONV_VALID_I(CONV_VALID_I),
    .CONV_OVER_I(CONV_OVER_I), .CONV_UNDER_I(CONV_UNDER_I), .RD_VALID_O(RD_VALID_O),
    .RD_DATA_O(RD_DATA_O), .FRM_CHAR_I(FRM_CHAR_I), .FRM_CHAR_VALID_I(FRM_CHAR_VALID_I),
    .FRM_END_O(FRM_END_O), .PROTO_MODBUS_O(PROTO_MODBUS_O), .COMM_ADDR_O(COMM_ADDR_O),
    .BAUD_DIV_O(BAUD_DIV_O), .CKSUM_EN_O(CKSUM_EN_O), .INIT_MODE_O(INIT_MODE_O));

/* verification/aosc_host.sv */
`timescale 1ns/1ps
module aosc_host
    import aosc_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic [DW-1:0] rdata_i,
    output logic      [AW-1:0] addr_o,
    output logic      [DW-1:0] wdata_o,
    output logic               wr_o,
    output logic               rd_o
);
    // Idle bus from time zero
    initial begin
        {addr_o, wdata_o, wr_o, rd_o} = '0;
    end
    // One-cycle write
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        #1;
    endtask
    // One-cycle read; data only in the next cycle
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        #1;
        d = rdata_i;
    endtask
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top
    import aosc_pkg::*;
;
    logic            clk, rst_n, init_sw, wdt_to, wdt_nv, cv, co, cu, fv, wr, rd;
    logic            rdv, fend, pmb, cken, imode;
    logic [AW-1:0]   addr;
    logic [DW-1:0]   wdata, rdata, rdd, rv;
    logic [CH_W-1:0] cch;
    logic [RD_W-1:0] cdat;
    logic [7:0]      fch, cks, caddr;
    logic [15:0]     bdiv;
    logic [DO_N-1:0] dout;
    logic [7:0]      fr [5] = '{8'h24, 8'h30, 8'h31, 8'h32, 8'h0D};
    int              bad_count, comparisons;

    aosc_top #(.SAFE_DEF(4'h0), .PWRON_DEF(4'hA)) dut (
        .CLK_SYS_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .INIT_SW_I(init_sw),
        .WDT_TIMEOUT_I(wdt_to), .WDT_STATUS_NV_I(wdt_nv), .CONV_VALID_I(cv),
        .CONV_CHAN_I(cch), .CONV_DATA_I(cdat), .CONV_OVER_I(co), .CONV_UNDER_I(cu),
        .RD_VALID_O(rdv), .RD_DATA_O(rv), .DO_O(dout), .FRM_CHAR_I(fch),
        .FRM_CHAR_VALID_I(fv), .FRM_CKSUM_O(cks), .FRM_END_O(fend), .PROTO_MODBUS_O(pmb),
        .COMM_ADDR_O(caddr), .BAUD_DIV_O(bdiv), .CKSUM_EN_O(cken), .INIT_MODE_O(imode));
    aosc_host host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Compare and count
    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Verdict and end of run
    task automatic close_out();
        $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Power-on reset with switch and stored watchdog status
    task automatic boot(input logic sw, input logic nv);
        @(posedge clk);
        init_sw <= sw;
        wdt_nv  <= nv;
        rst_n   <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
    endtask
    // One conversion result, checked after its edge
    task automatic conv(input logic [2:0] ch, input logic [15:0] d, input logic ov, un);
        @(posedge clk);
        {cv, cch, cdat, co, cu} <= {1'b1, ch, d, ov, un};
        @(posedge clk);
        {cv, co, cu} <= 3'h0;
        #1;
        chk(rdv, 32'h1);
    endtask
    // Hang guard
    initial begin
        repeat (4000) @(posedge clk);
        bad_count++;
        close_out();
    end
    // Main sequence
    initial begin
        {rst_n, init_sw, wdt_to, wdt_nv, cv, co, cu, fv, cch, cdat, fch} = '0;
        bad_count = 0;
        comparisons = 0;
        boot(1'b0, 1'b0);
        chk(pmb, 32'h1);
        host.rd(A_CTRL, rdd);
        chk(rdd & 32'h4, 32'h4);
        $display("test 1 done");
        host.wr(A_FMT, 32'h0);
        conv(3'h0, 16'h0000, 1'b1, 1'b0);
        chk(rv, OVR_HEX);
        conv(3'h0, 16'h0000, 1'b0, 1'b1);
        chk(rv, UND_HEX);
        host.wr(A_CSEL, 32'h3);
        host.wr(A_CDATA, 32'hC3694000);
        host.rd(A_CDATA, rdd);
        chk(rdd, 32'hC3694000);
        host.rd(A_CINFO, rdd);
        chk(rdd, 32'h80000007);
        $display("test 2 done");
        host.wr(8'h40, 32'h64);
        host.wr(8'h44, 32'h215);
        host.wr(A_DOWR, 32'hF);
        conv(3'h1, 16'h00C8, 1'b0, 1'b0);
        chk(dout, 32'hF);
        conv(3'h1, 16'h0032, 1'b0, 1'b0);
        chk(dout, 32'hB);
        conv(3'h0, 16'h00C8, 1'b0, 1'b0);
        chk(dout, 32'hB);
        $display("test 3 done");
        host.wr(8'h48, 32'h0);
        host.wr(8'h4C, 32'h23);
        conv(3'h2, 16'hFFFB, 1'b0, 1'b0);
        chk(dout, 32'hB);
        conv(3'h2, 16'h000A, 1'b0, 1'b0);
        chk(dout, 32'hB);
        host.wr(A_ALMCLR, 32'h2);
        host.rd(A_ALMSTAT, rdd);
        chk(rdd, 32'h0);
        chk(dout, 32'hA);
        $display("test 4 done");
        host.wr(A_SAFE, 32'h0);
        @(posedge clk);
        wdt_to <= 1'b1;
        @(posedge clk);
        wdt_to <= 1'b0;
        host.rd(A_CTRL, rdd);
        chk(rdd & 32'h1, 32'h1);
        chk(dout, 32'h0);
        host.wr(A_DOWR, 32'hF);
        host.wr(A_CTRL, 32'h1);
        chk(dout, 32'h0);
        host.wr(A_DOWR, 32'hF);
        #40;
        chk(dout, 32'hA);
        $display("test 5 done");
        host.wr(A_COMM, 32'h0701);
        host.wr(A_PSEL, 32'h00010646);
        chk(pmb, 32'h1);
        boot(1'b0, 1'b0);
        chk(pmb, 32'h0);
        chk(bdiv, 32'hD9);
        chk(dout & 4'hA, 32'hA);
        host.wr(A_FMT, 32'(FMT_ENG));
        conv(3'h0, 16'h0000, 1'b1, 1'b0);
        chk(rv, OVR_ENG);
        host.wr(A_FMT, 32'(FMT_PCT));
        conv(3'h0, 16'h0000, 1'b0, 1'b1);
        chk(rv, UND_PCT);
        $display("test 6 done");
        boot(1'b1, 1'b1);
        chk({imode, cken, pmb, caddr, bdiv}, {3'h4, INIT_ADDR, 16'h0A2C});
        chk(dout & 4'hA, 32'h0);
        host.wr(A_PSEL, 32'h01010000);
        boot(1'b0, 1'b0);
        chk(pmb, 32'h1);
        $display("test 7 done");
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            fv  <= 1'b1;
            fch <= fr[i];
        end
        @(posedge clk);
        fv <= 1'b0;
        #1;
        chk({fend, cks}, 32'h1B7);
        $display("test 8 done");
        close_out();
    end
endmodule
